// *** hw/pmet_pkg.sv ***
// Constants, register map and types of the power management event timers
package pmet_pkg;
  // Clock and time bases
  localparam int unsigned    CLK_NS      = 20;
  localparam int unsigned    CLK_KHZ     = 50_000;
  localparam int unsigned    FAST_MS     = 600;      // 0.6 seconds
  localparam int unsigned    SLOW_MS     = 75_000;   // 1.25 minutes
  localparam int unsigned    GEN_MS      = 300;      // 0.3 seconds
  localparam longint unsigned FAST_CYC   = longint'(FAST_MS) * CLK_KHZ;
  localparam longint unsigned SLOW_CYC   = longint'(SLOW_MS) * CLK_KHZ;
  localparam longint unsigned GEN_CYC    = longint'(GEN_MS) * CLK_KHZ;
  localparam int unsigned    TB_NS       = 35_000;   // 35 us unit
  localparam logic [11:0]    TB_CYC      = 12'((TB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0]     PULSE_CYC   = 3'h4;     // Pulse length in clocks
  localparam logic [1:0]     INIT_GAP    = 2'h2;     // Quiet clocks after init

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_TEN    = 12'h004;
  localparam logic [11:0] OFF_CMD    = 12'h008;
  localparam logic [11:0] OFF_RLD0   = 12'h010;
  localparam logic [11:0] OFF_MASK0  = 12'h020;
  localparam logic [11:0] OFF_THR    = 12'h030;
  localparam logic [11:0] OFF_BLK    = 12'h034;
  localparam logic [11:0] OFF_SEL    = 12'h038;
  localparam logic [11:0] OFF_STAT   = 12'h03c;
  localparam logic [11:0] OFF_STATE  = 12'h040;
  localparam logic [11:0] OFF_SWRLD  = 12'h08c;
  localparam logic [11:0] OFF_MBOX0  = 12'h0c8;

  // Control and command fields
  localparam int CTL_MGMT_EN = 0;
  localparam int CTL_FB_MODE = 1;
  localparam int CTL_IRQ_LO  = 2;
  localparam int CTL_THR_EN  = 4;
  localparam int CMD_SW_STOP = 0;
  localparam int CMD_SW_MGMT = 1;
  localparam int CMD_CLR_BLK = 2;
  localparam int CMD_UNBLK_X = 3;

  // Reset values
  localparam logic [4:0]  CTRL_RST = 5'h00;
  localparam logic [7:0]  CNT_RST  = 8'hff;
  localparam logic [8:0]  MASK_RST = 9'h1ff;
  localparam logic [14:0] SEL_RST  = 15'h0000;
  // Idle pin levels: NMI and break high, the rest low, so no false edge after reset
  localparam logic [12:0] SYNC_RST = 13'h1800;

  // System event lines (timer reload sources)
  localparam int EV_PCI = 0;
  localparam int EV_IOT = 1;
  localparam int EV_SER = 2;
  localparam int EV_PAR = 3;
  localparam int EV_DSK = 4;
  localparam int EV_KBD = 5;
  localparam int EV_DMA = 6;
  localparam int EV_IRQ = 7;
  localparam int EV_VID = 8;
  localparam int NEV    = 9;
  localparam int NSRC   = 15;

  // Timer indices
  localparam int T_FAST = 0;
  localparam int T_SLOW = 1;
  localparam int T_GEN  = 2;

  typedef enum logic [1:0] {
    G_IDLE  = 2'b00,
    G_PULSE = 2'b01,
    G_BLOCK = 2'b10
  } pmet_gen_t;
endpackage

// *** hw/pmet_top.sv ***
// Power management event timers, interrupt and stop-clock control with APB registers
// What this block does
// - Fast idle timer decrements every 0.6 seconds.
// - Slow idle timer decrements every 1.25 minutes.
// - Generic idle timer decrements every 0.3 seconds.
// - Timer expires only after its monitored events stay idle; any event fits any timer.
// - Per-timer mask picks which of nine system events reload it.
// - Enabling reloads the count; expiry becomes valid one clock later.
// - Timers run always; expiry is produced only while enabled.
// - A write to offset 8Ch reloads the idle timers like an event.
// - Expired state sticks until the timer is disabled; disabling clears it.
// - Any timer expiry can raise a management interrupt or stop-clock.
// - Fifteen listed sources can raise the management interrupt.
// - Stop-clock asserts on timer expiry, software trigger or throttle active expiry.
// - Stop-clock releases on break, IRQ, NMI, DMA, PCI request or throttle idle expiry.
// - Fallback mode raises one selectable IRQ line instead of the pulse.
// - No nested interrupts; new ones wait until the nesting block timer expires.
// - Throttle uses an active count and an idle count for stop-clock phases.
// - Throttle and nesting block timers count in 35 us units.
// - Four read/write mailbox registers.
// - Status bits show the cause; writing one clears, zero does nothing.
// - Management interrupt pulse lasts four clocks.
// - No management interrupt pulse during CPU init, nor within two clocks after it ends.
`timescale 1ns/1ps
`default_nettype none
module pmet_top
  import pmet_pkg::*;
#(
  parameter longint unsigned FAST_TICK = pmet_pkg::FAST_CYC,
  parameter longint unsigned SLOW_TICK = pmet_pkg::SLOW_CYC,
  parameter longint unsigned GEN_TICK  = pmet_pkg::GEN_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [8:0]  sys_event,
  input  wire logic        gpio_event,
  input  wire logic        external_break_n,
  input  wire logic        nmi_n,
  input  wire logic        cpu_init,
  output logic             mgmt_int_n,
  output logic [3:0]       mgmt_fallback_irq,
  output logic             cpu_clock_halt_n
);
  import pmet_pkg::*;

  function automatic logic hit_wr(input logic [11:0] off, input logic [11:0] a,
                                  input logic wr);
    hit_wr = wr && (a == off);
  endfunction

  // Input synchronisers; stage 3 is only for edge detection
  logic [12:0] s1_r, s2_r, s3_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
    end else begin
      s1_r <= {nmi_n, external_break_n, gpio_event, cpu_init, sys_event};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic [8:0] ev_s, ev_rise;
  logic       init_s, gpio_rise, ext_rise, nmi_fall;
  assign ev_s      = s2_r[8:0];
  assign ev_rise   = s2_r[8:0] & ~s3_r[8:0];
  assign init_s    = s2_r[9];
  assign gpio_rise = s2_r[10] & ~s3_r[10];
  assign ext_rise  = s2_r[11] & ~s3_r[11];
  assign nmi_fall  = ~s2_r[12] & s3_r[12];

  // APB slave: zero wait, read data captured in the setup cycle
  logic wr_en;
  assign wr_en   = psel && penable && pwrite;
  assign pready  = psel && penable;

  logic [4:0]  ctrl_r;
  logic [2:0]  ten_r, ten_q, expired_r;
  logic [7:0]  rld_r [3];
  logic [8:0]  mask_r [3];
  logic [7:0]  on_cnt_r, off_cnt_r, blk_set_r;
  logic [14:0] sel_r, status_r;
  logic [31:0] mbox_r [4];
  logic [7:0]  cnt_r [3];
  logic        stop_r, ext_blk_r, fb_r;
  logic        cmd_sw_stop, cmd_sw_mgmt, cmd_clr_blk, cmd_unblk, sw_rld;
  pmet_gen_t   gen_r;

  assign cmd_sw_stop = hit_wr(OFF_CMD, paddr, wr_en) && pwdata[CMD_SW_STOP];
  assign cmd_sw_mgmt = hit_wr(OFF_CMD, paddr, wr_en) && pwdata[CMD_SW_MGMT];
  assign cmd_clr_blk = hit_wr(OFF_CMD, paddr, wr_en) && pwdata[CMD_CLR_BLK];
  assign cmd_unblk   = hit_wr(OFF_CMD, paddr, wr_en) && pwdata[CMD_UNBLK_X];
  assign sw_rld      = hit_wr(OFF_SWRLD, paddr, wr_en);

  logic [31:0] rdata_nxt;
  logic        hit;
  always_comb begin
    rdata_nxt = 32'h0;
    hit       = 1'b1;
    case (paddr)
      OFF_CTRL:          rdata_nxt = {27'h0, ctrl_r};
      OFF_TEN:           rdata_nxt = {25'h0, expired_r, 1'b0, ten_r};
      OFF_CMD:           rdata_nxt = 32'h0;
      OFF_RLD0:          rdata_nxt = {24'h0, rld_r[0]};
      OFF_RLD0 + 12'h4:  rdata_nxt = {24'h0, rld_r[1]};
      OFF_RLD0 + 12'h8:  rdata_nxt = {24'h0, rld_r[2]};
      OFF_MASK0:         rdata_nxt = {23'h0, mask_r[0]};
      OFF_MASK0 + 12'h4: rdata_nxt = {23'h0, mask_r[1]};
      OFF_MASK0 + 12'h8: rdata_nxt = {23'h0, mask_r[2]};
      OFF_THR:           rdata_nxt = {16'h0, off_cnt_r, on_cnt_r};
      OFF_BLK:           rdata_nxt = {24'h0, blk_set_r};
      OFF_SEL:           rdata_nxt = {17'h0, sel_r};
      OFF_STAT:          rdata_nxt = {17'h0, status_r};
      OFF_STATE:         rdata_nxt = {3'h0, fb_r, ext_blk_r, stop_r, gen_r,
                                      cnt_r[2], cnt_r[1], cnt_r[0]};
      OFF_SWRLD:         rdata_nxt = 32'h0;
      OFF_MBOX0:         rdata_nxt = mbox_r[0];
      OFF_MBOX0 + 12'h4: rdata_nxt = mbox_r[1];
      OFF_MBOX0 + 12'h8: rdata_nxt = mbox_r[2];
      OFF_MBOX0 + 12'hc: rdata_nxt = mbox_r[3];
      default:           hit       = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= rdata_nxt;
    end
  end

  // Plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= CTRL_RST;
      ten_r     <= 3'h0;
      on_cnt_r  <= CNT_RST;
      off_cnt_r <= CNT_RST;
      blk_set_r <= CNT_RST;
      sel_r     <= SEL_RST;
      for (int i = 0; i < 3; i++) begin
        rld_r[i]  <= CNT_RST;
        mask_r[i] <= MASK_RST;
      end
      for (int i = 0; i < 4; i++) begin
        mbox_r[i] <= 32'h0;
      end
    end else begin
      if (hit_wr(OFF_CTRL, paddr, wr_en)) ctrl_r <= pwdata[4:0];
      if (hit_wr(OFF_TEN, paddr, wr_en)) ten_r <= pwdata[2:0];
      if (hit_wr(OFF_THR, paddr, wr_en)) begin
        on_cnt_r  <= pwdata[7:0];
        off_cnt_r <= pwdata[15:8];
      end
      if (hit_wr(OFF_BLK, paddr, wr_en)) blk_set_r <= pwdata[7:0];
      if (hit_wr(OFF_SEL, paddr, wr_en)) sel_r <= pwdata[14:0];
      for (int i = 0; i < 3; i++) begin
        if (hit_wr(OFF_RLD0 + 12'(4 * i), paddr, wr_en)) rld_r[i] <= pwdata[7:0];
        if (hit_wr(OFF_MASK0 + 12'(4 * i), paddr, wr_en)) mask_r[i] <= pwdata[8:0];
      end
      for (int i = 0; i < 4; i++) begin
        if (hit_wr(OFF_MBOX0 + 12'(4 * i), paddr, wr_en)) mbox_r[i] <= pwdata;
      end
    end
  end

  // Time bases: one-cycle enables from free dividers
  logic [63:0] div_r [3];
  logic [11:0] tb_div_r;
  logic [2:0]  tick;
  logic        tb_tick;
  localparam longint unsigned TICKS [3] = '{FAST_TICK, SLOW_TICK, GEN_TICK};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) div_r[i] <= 64'h0;
      tb_div_r <= 12'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        div_r[i] <= tick[i] ? 64'h0 : div_r[i] + 64'h1;
      end
      tb_div_r <= tb_tick ? 12'h0 : tb_div_r + 12'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) tick[i] = (div_r[i] == TICKS[i] - 64'h1);
  end
  assign tb_tick = (tb_div_r == TB_CYC - 12'h1);

  // Idle timers: free running, gated expiry
  logic [2:0] en_rise, en_valid, reload, exp_set;
  assign en_rise  = ten_r & ~ten_q;
  assign en_valid = ten_r & ten_q;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      reload[i]  = en_rise[i] || sw_rld || |(ev_s & mask_r[i]);
      exp_set[i] = en_valid[i] && !expired_r[i] && !reload[i] && cnt_r[i] == 8'h0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ten_q     <= 3'h0;
      expired_r <= 3'h0;
      for (int i = 0; i < 3; i++) cnt_r[i] <= CNT_RST;
    end else begin
      ten_q     <= ten_r;
      expired_r <= (expired_r | exp_set) & ten_r;
      for (int i = 0; i < 3; i++) begin
        if (reload[i]) cnt_r[i] <= rld_r[i];
        else if (tick[i] && cnt_r[i] != 8'h0) cnt_r[i] <= cnt_r[i] - 8'h1;
      end
    end
  end

  // External break: rising edge, then ignored until software unblocks it
  logic ext_evt;
  assign ext_evt = ext_rise && !ext_blk_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_blk_r <= 1'b0;
    else if (ext_evt) ext_blk_r <= 1'b1;
    else if (cmd_unblk) ext_blk_r <= 1'b0;
  end

  // Management event status; a new event wins over a clearing write
  logic [14:0] src;
  assign src = {gpio_rise, ev_rise[EV_IRQ], exp_set[T_SLOW], exp_set[T_GEN],
                exp_set[T_FAST], ev_rise[EV_SER], ev_rise[EV_PAR], ev_rise[EV_VID],
                ev_rise[EV_DSK], ev_rise[EV_KBD], ext_evt, cmd_sw_mgmt,
                ev_rise[EV_IOT], ev_rise[EV_PCI], ev_rise[EV_DMA]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 15'h0;
    end else begin
      status_r <= (status_r & ~(hit_wr(OFF_STAT, paddr, wr_en) ? pwdata[14:0] : 15'h0))
                  | (src & sel_r & {NSRC{ctrl_r[CTL_MGMT_EN]}});
    end
  end

  // Interrupt generator with nesting block and init qualification
  logic       req, start;
  logic [2:0] pcnt_r;
  logic [1:0] gap_r;
  logic [7:0] blk_cnt_r;
  logic       blk_arm_r;
  assign req   = |status_r && ctrl_r[CTL_MGMT_EN];
  assign start = gen_r == G_IDLE && req && (ctrl_r[CTL_FB_MODE] ||
                 (!init_s && gap_r == 2'h0));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_r <= 2'h0;
    else if (init_s) gap_r <= INIT_GAP;
    else if (gap_r != 2'h0) gap_r <= gap_r - 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_r     <= G_IDLE;
      pcnt_r    <= 3'h0;
      blk_cnt_r <= 8'h0;
      blk_arm_r <= 1'b0;
    end else begin
      if (cmd_clr_blk) blk_arm_r <= 1'b1;
      case (gen_r)
        G_IDLE: begin
          if (start) begin
            gen_r     <= ctrl_r[CTL_FB_MODE] ? G_BLOCK : G_PULSE;
            pcnt_r    <= 3'h1;
            blk_cnt_r <= blk_set_r;
            blk_arm_r <= 1'b0;
          end
        end
        G_PULSE: begin
          pcnt_r <= pcnt_r + 3'h1;
          // Init wins: the pulse is cut short, never stretched
          if (init_s || pcnt_r == PULSE_CYC) gen_r <= G_BLOCK;
        end
        G_BLOCK: begin
          if (blk_arm_r && blk_cnt_r == 8'h0) gen_r <= G_IDLE;
          else if (blk_arm_r && tb_tick) blk_cnt_r <= blk_cnt_r - 8'h1;
        end
        default: gen_r <= G_IDLE;
      endcase
    end
  end
  assign mgmt_int_n = !(gen_r == G_PULSE && !init_s);

  // Fallback IRQ level: not init-qualified, held while causes stay set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_r              <= 1'b0;
      mgmt_fallback_irq <= 4'h0;
    end else begin
      fb_r <= req && ctrl_r[CTL_FB_MODE] && (fb_r || start);
      mgmt_fallback_irq <= (req && ctrl_r[CTL_FB_MODE] && (fb_r || start))
                           ? (4'h1 << ctrl_r[CTL_IRQ_LO +: 2]) : 4'h0;
    end
  end

  // Throttling timer and stop-clock
  logic [7:0] thr_cnt_r;
  logic       stop_q, thr_on_exp, thr_off_exp, thr_due, stop_set, stop_clr;
  assign thr_due     = ctrl_r[CTL_THR_EN] && stop_r == stop_q && thr_cnt_r == 8'h0
                       && tb_tick;
  assign thr_on_exp  = thr_due && !stop_r;
  assign thr_off_exp = thr_due && stop_r;
  assign stop_set = |exp_set || cmd_sw_stop || thr_on_exp;
  assign stop_clr = ext_evt || ev_rise[EV_IRQ] || nmi_fall || ev_rise[EV_DMA]
                    || ev_rise[EV_PCI] || thr_off_exp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_r    <= 1'b0;
      stop_q    <= 1'b0;
      thr_cnt_r <= CNT_RST;
    end else begin
      stop_q <= stop_r;
      // Wake events take priority so a stuck assert source cannot lock the CPU
      if (stop_clr) stop_r <= 1'b0;
      else if (stop_set) stop_r <= 1'b1;
      if (!ctrl_r[CTL_THR_EN]) thr_cnt_r <= on_cnt_r;
      else if (stop_r != stop_q) thr_cnt_r <= stop_r ? off_cnt_r : on_cnt_r;
      else if (!stop_r && |ev_s) thr_cnt_r <= on_cnt_r;
      else if (tb_tick && thr_cnt_r != 8'h0) thr_cnt_r <= thr_cnt_r - 8'h1;
    end
  end
  assign cpu_clock_halt_n = !stop_r;

  // Checks
  property p_pulse_len;
    @(posedge pclk) disable iff (!presetn || init_s)
    $fell(mgmt_int_n) |-> !mgmt_int_n [*4] ##1 mgmt_int_n;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse not four clocks");

  property p_init_quiet;
    @(posedge pclk) disable iff (!presetn) init_s |-> mgmt_int_n;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("interrupt during init");

  property p_init_gap;
    @(posedge pclk) disable iff (!presetn) $fell(init_s) |-> mgmt_int_n [*3];
  endproperty
  a_init_gap: assert property (p_init_gap) else $error("interrupt too soon after init");

  property p_no_nest;
    @(posedge pclk) disable iff (!presetn)
    $fell(mgmt_int_n) |-> $past(gen_r) == G_IDLE;
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("nested interrupt");

  property p_en_delay;
    @(posedge pclk) disable iff (!presetn) |en_rise |=> (exp_set & $past(en_rise)) == 3'h0;
  endproperty
  a_en_delay: assert property (p_en_delay) else $error("expiry right after enable");

  property p_exp_gated;
    @(posedge pclk) disable iff (!presetn) (exp_set & ~ten_r) == 3'h0;
  endproperty
  a_exp_gated: assert property (p_exp_gated) else $error("expiry while disabled");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    expired_r[T_FAST] && ten_r[T_FAST] |=> expired_r[T_FAST] || !$past(ten_r[T_FAST], 1);
  endproperty
  a_sticky: assert property (p_sticky) else $error("expired state lost");

  property p_stop_on;
    @(posedge pclk) disable iff (!presetn) stop_set && !stop_clr |=> !cpu_clock_halt_n;
  endproperty
  a_stop_on: assert property (p_stop_on) else $error("stop-clock not asserted");

  property p_stop_off;
    @(posedge pclk) disable iff (!presetn) stop_clr |=> cpu_clock_halt_n;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop-clock not released");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
    |($past(status_r) & ~status_r) |-> $past(hit_wr(OFF_STAT, paddr, wr_en));
  endproperty
  a_w1c: assert property (p_w1c) else $error("status cleared without write");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    reload[T_GEN] |=> cnt_r[T_GEN] == $past(rld_r[T_GEN]);
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded");

  property p_cov_pulse;
    @(posedge pclk) $fell(mgmt_int_n);
  endproperty
  c_cov_pulse: cover property (p_cov_pulse);

  property p_cov_thr;
    @(posedge pclk) thr_off_exp;
  endproperty
  c_cov_thr: cover property (p_cov_thr);

  property p_cov_fb;
    @(posedge pclk) |mgmt_fallback_irq;
  endproperty
  c_cov_fb: cover property (p_cov_fb);
endmodule
`default_nettype wire

// *** test/pmet_cpu_model.sv ***
// Host CPU stand-in: watches the management interrupt, drives init and NMI
`timescale 1ns/1ps
`default_nettype none
module pmet_cpu_model (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      cpu_init,
  output logic      nmi_n,
  input  wire logic mgmt_int_n
);
  int n_pulse = 0;
  int pulse_w = 0;
  int run     = 0;
  initial begin
    cpu_init = 1'h0;
    nmi_n = 1'h1;
  end
  // Width is counted at rising edges, the way the CPU samples the pin
  always @(posedge pclk) begin
    if (!presetn) begin
      run <= 0;
    end else if (mgmt_int_n === 1'h0) begin
      run <= run + 1;
    end else if (run != 0) begin
      n_pulse <= n_pulse + 1;
      pulse_w <= run;
      run <= 0;
    end
  end
  task automatic set_init(input logic v);
    @(posedge pclk);
    cpu_init <= v;
  endtask
  task automatic pulse_nmi();
    @(posedge pclk);
    nmi_n <= 1'h0;
    repeat (4) @(posedge pclk);
    nmi_n <= 1'h1;
  endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the power management event timers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import pmet_pkg::*;
  localparam longint unsigned TK [3] = '{64'h8, 64'h14, 64'h4};
  localparam int EVR [4] = '{0, EV_DMA, EV_PCI, EV_IRQ};
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [8:0]  sys_event = 9'h0;
  logic        gpio_event = 1'h0;
  logic        external_break_n = 1'h1;
  logic        nmi_n;
  logic        cpu_init;
  logic        mgmt_int_n;
  logic        cpu_clock_halt_n;
  logic [3:0]  mgmt_fallback_irq;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          t0;
  int          k;

  pmet_top #(.FAST_TICK(TK[0]), .SLOW_TICK(TK[1]), .GEN_TICK(TK[2])) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_event(sys_event), .gpio_event(gpio_event), .external_break_n(external_break_n),
    .nmi_n(nmi_n), .cpu_init(cpu_init), .mgmt_int_n(mgmt_int_n),
    .mgmt_fallback_irq(mgmt_fallback_irq), .cpu_clock_halt_n(cpu_clock_halt_n));
  pmet_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .cpu_init(cpu_init),
    .nmi_n(nmi_n), .mgmt_int_n(mgmt_int_n));

  always #10 pclk = ~pclk;
  // Ceiling covers three block waits and the throttle cycle with margin
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wt, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wt;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // No timeout here; if pready never rises, only the bench watchdog ends this wait
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rg(input logic [11:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  // Each poll is one three-edge read, so c counts clocks
  task automatic wait_exp(input int t, output int c);
    c = 0;
    rd = 32'h0;
    while (rd[4+t] !== 1'h1 && c < 400) begin
      rg(OFF_TEN);
      c += 3;
    end
  endtask
  task automatic wait_int(output int c);
    int n0;
    n0 = u_cpu.n_pulse;
    c = 0;
    while (u_cpu.n_pulse == n0 && c < 6000) begin
      c++;
      @(posedge pclk);
    end
  endtask
  task automatic wait_halt(input logic v, output int c);
    c = 0;
    while (cpu_clock_halt_n !== v && c < 8000) begin
      c++;
      @(posedge pclk);
    end
  endtask
  task automatic unblock();
    wr(OFF_STAT, 32'h7fff);
    wr(OFF_CMD, 32'h4);
    w(3 * TB_CYC + 40);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rg(OFF_MASK0 + 12'h4); `CHK(rd[8:0], MASK_RST)
    rg(OFF_RLD0); `CHK(rd[7:0], CNT_RST)
    for (k = 0; k < 4; k++)
      wr(OFF_MBOX0 + 12'(4 * k), 32'ha5c3_0f00 + 32'(k));
    for (k = 0; k < 4; k++) begin
      rg(OFF_MBOX0 + 12'(4 * k)); `CHK(rd, 32'ha5c3_0f00 + 32'(k))
    end
    rg(12'h100); `CHK({err, rd}, 33'h1_0000_0000)
    for (k = 0; k < 3; k++) begin
      wr(OFF_RLD0 + 12'(4 * k), 32'h4);
      wr(OFF_MASK0 + 12'(4 * k), 32'h010);
      // Activity on a line left out of the mask must not hold the timer
      sys_event[EV_KBD] <= 1'h1;
      wr(OFF_TEN, 32'h1 << k);
      rg(OFF_TEN); `CHK(rd[4+k], 1'h0)
      wait_exp(k, t0); `CHK(t0 >= 3 * TK[k] && t0 <= 5 * TK[k] + 12, 1'h1)
      w(40);
      rg(OFF_TEN); `CHK(rd[4+k], 1'h1)
      wr(OFF_TEN, 32'h0);
      rg(OFF_TEN); `CHK(rd[4+k], 1'h0)
      sys_event[EV_DSK] <= 1'h1;
      wr(OFF_TEN, 32'h1 << k);
      w(150);
      rg(OFF_TEN); `CHK(rd[4+k], 1'h0)
      sys_event <= 9'h0;
      repeat (8) begin
        w(int'(TK[k] / 2));
        wr(OFF_SWRLD, 32'h0);
      end
      rg(OFF_TEN); `CHK(rd[4+k], 1'h0)
      wait_exp(k, t0); `CHK(t0 < 400, 1'h1)
      wr(OFF_TEN, 32'h0);
    end
    wr(OFF_SEL, 32'h4408);
    wr(OFF_BLK, 32'h2);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_RLD0, 32'h1);
    wr(OFF_TEN, 32'h1);
    wait_int(t0); `CHK(u_cpu.pulse_w, 4)
    rg(OFF_STAT); `CHK(rd[10], 1'h1)
    wr(OFF_TEN, 32'h0);
    wr(OFF_STAT, 32'h0);
    rg(OFF_STAT); `CHK(rd[10], 1'h1)
    wr(OFF_STAT, 32'h7fff);
    rg(OFF_STAT); `CHK(rd[14:0], 15'h0)
    gpio_event <= 1'h1;
    w(6);
    rg(OFF_STAT); `CHK(rd[14], 1'h1)
    k = u_cpu.n_pulse;
    wr(OFF_CMD, 32'h2);
    w(60); `CHK(u_cpu.n_pulse, k)
    wr(OFF_CMD, 32'h4);
    wait_int(t0); `CHK(t0 >= TB_CYC && t0 <= 3 * TB_CYC + 40, 1'h1)
    unblock();
    u_cpu.set_init(1'h1);
    k = u_cpu.n_pulse;
    wr(OFF_CMD, 32'h2);
    w(30); `CHK(u_cpu.n_pulse, k)
    u_cpu.set_init(1'h0);
    wait_int(t0); `CHK(t0 >= 2 && t0 <= 14, 1'h1)
    unblock();
    for (k = 0; k < 5; k++) begin
      wr(OFF_CMD, 32'h1);
      w(3); `CHK(cpu_clock_halt_n, 1'h0)
      if (k == 0) begin
        u_cpu.pulse_nmi();
      end else if (k < 4) begin
        sys_event[EVR[k]] <= 1'h1;
        w(4);
        sys_event <= 9'h0;
      end else begin
        external_break_n <= 1'h0;
        w(4);
        external_break_n <= 1'h1;
      end
      w(8); `CHK(cpu_clock_halt_n, 1'h1)
    end
    wr(OFF_CMD, 32'h8);
    // Fallback also goes through the block; a zero count lets re-arming free it at once
    wr(OFF_BLK, 32'h0);
    for (k = 0; k < 4; k++) begin
      wr(OFF_CTRL, 32'h3 | 32'(k << 2));
      t0 = u_cpu.n_pulse;
      wr(OFF_CMD, 32'h2);
      w(8); `CHK(mgmt_fallback_irq, 4'h1 << k)
      `CHK(u_cpu.n_pulse, t0)
      wr(OFF_STAT, 32'h7fff);
      w(4); `CHK(mgmt_fallback_irq, 4'h0)
      wr(OFF_CMD, 32'h4);
    end
    wr(OFF_THR, 32'h0102);
    wr(OFF_CTRL, 32'h10);
    wait_halt(1'h0, t0); `CHK(t0 >= TB_CYC && t0 <= 3 * TB_CYC + 20, 1'h1)
    wait_halt(1'h1, t0); `CHK(t0 <= 2 * TB_CYC + 20, 1'h1)
    test_done();
  end
endmodule
`default_nettype wire
